// ---- can_mask_pkg.sv ----
// Constants and types shared by the extended-identifier mask block
package can_mask_pkg;

    // Register map, byte addresses on the internal register port
    localparam logic [7:0] ADDR_MASK0_EXT_ID_HIGH = 8'h22;
    localparam logic [7:0] ADDR_MASK0_EXT_ID_LOW  = 8'h23;
    localparam logic [7:0] ADDR_MASK1_EXT_ID_HIGH = 8'h26;
    localparam logic [7:0] ADDR_MASK1_EXT_ID_LOW  = 8'h27;
    localparam logic [7:0] MASK_ADDR_STRIDE       = 8'h04;

    // Widths and reset values
    localparam int         NUM_MASKS      = 2;
    localparam int         REG_WIDTH      = 8;
    localparam int         EXT_ID_WIDTH   = 18;
    localparam int         EXT_TOP_WIDTH  = 2;
    localparam int         OP_FIELD_WIDTH = 2;
    localparam logic [7:0] MASK_RESET     = 8'h00;
    localparam logic [7:0] READ_ZERO      = 8'h00;

    // Field positions inside the 18-bit extended identifier
    localparam int EXT_LOW_LSB  = 0;
    localparam int EXT_HIGH_LSB = 8;
    localparam int EXT_TOP_LSB  = 16;

    // Receive-buffer operating field value that enables data-byte filtering
    localparam logic [1:0] OP_FIELD_DATA_FILTER = 2'h0;

    typedef logic [REG_WIDTH-1:0]      byte_t;
    typedef logic [EXT_ID_WIDTH-1:0]   ext_id_t;
    typedef logic [EXT_TOP_WIDTH-1:0]  ext_top_t;
    typedef logic [OP_FIELD_WIDTH-1:0] op_field_t;

endpackage

// ---- mask_match_if.sv ----
// Carrier between the mask register file and one mask comparison unit
`timescale 1ns/1ns
interface mask_match_if;
    import can_mask_pkg::*;

    byte_t     mask_high;       // Mask for extended id bits 15:8
    byte_t     mask_low;        // Mask for extended id bits 7:0 or data byte 1
    ext_top_t  mask_top;        // Mask for extended id bits 17:16
    ext_id_t   filter_ext_id;   // Filter value, extended id part
    byte_t     filter_byte1;    // Filter value for data byte 1
    op_field_t op_field;        // Operating field of the associated buffer
    logic      ext_id_flag;     // Frame carries an extended identifier
    ext_id_t   frame_ext_id;    // Received extended identifier bits
    byte_t     frame_byte1;     // Received data byte 1
    logic      match;           // Extended part of the acceptance test passed

    modport owner (output mask_high, mask_low, mask_top, filter_ext_id, filter_byte1,
                   op_field, ext_id_flag, frame_ext_id, frame_byte1, input match);
    modport unit  (input mask_high, mask_low, mask_top, filter_ext_id, filter_byte1,
                   op_field, ext_id_flag, frame_ext_id, frame_byte1, output match);
endinterface

// ---- mask_match_unit.sv ----
// Combinational comparison of one acceptance mask against a received frame
`timescale 1ns/1ns
module mask_match_unit
    import can_mask_pkg::*;
(
    mask_match_if.unit m
);
    ext_id_t full_mask;
    ext_id_t id_diff;
    byte_t   byte_diff;
    logic    data_mode;

    // Assemble the 18-bit mask from its three pieces
    always_comb
    begin
        full_mask = {m.mask_top, m.mask_high, m.mask_low};                   // [R1] [R5] [R6]
        id_diff   = (m.frame_ext_id ^ m.filter_ext_id) & full_mask;
        byte_diff = (m.frame_byte1 ^ m.filter_byte1) & m.mask_low;
        data_mode = (m.op_field == OP_FIELD_DATA_FILTER) && !m.ext_id_flag;  // [R2]
    end

    // Standard frames outside data-filter mode have no extended part to test
    always_comb
    begin
        if (data_mode)
        begin
            m.match = (byte_diff == READ_ZERO);
        end
        else if (m.ext_id_flag)
        begin
            m.match = (id_diff == '0);
        end
        else
        begin
            m.match = 1'b1;
        end
    end
endmodule

// ---- can_ext_id_acceptance_mask.sv ----
// Extended-identifier acceptance mask registers and their frame comparison
//
// Notes on behaviour
// R1: Low mask byte masks extended identifier bits 7 to 0 of received frames.
// R2: Operating field 00 and standard frame: low mask byte masks data byte 1.
// R3: All mask registers read zero outside Configuration mode; stored values still filter.
// R4: Low mask bytes at 23h and 27h, eight-bit read/write, reset to zero.
// R5: Separate mask field covers extended identifier bits 17 and 16.
// R6: High mask bytes at 22h and 26h reset to zero, mask bits 15 to 8.
//
// Mask g sits at byte address 22h + 4g (high byte) and 23h + 4g (low byte)
// Mask bits 17:16 arrive on a port; their register lives with the standard-id masks
// Writes outside Configuration mode are dropped without any indication to the host
// The match result covers the extended part only; the standard part is judged elsewhere
`timescale 1ns/1ns
module can_ext_id_acceptance_mask
    import can_mask_pkg::*;
#(
    parameter int N_MASKS = NUM_MASKS
)
(
    input  wire logic                            core_clk_in,
    input  wire logic                            arst_n_in,
    // Register port from the serial command decoder
    input  wire logic [7:0]                      reg_addr_in,
    input  wire logic                            reg_wr_en_in,
    input  wire logic [REG_WIDTH-1:0]            reg_wr_data_in,
    input  wire logic                            reg_rd_en_in,
    output logic      [REG_WIDTH-1:0]            reg_rd_data_out,
    // Operating mode from the mode controller
    input  wire logic                            config_mode_in,
    // Mask bits 17:16, one pair per mask, held in the standard-id mask registers
    input  wire logic [N_MASKS*EXT_TOP_WIDTH-1:0] mask_ext_top_in,
    // Filter values selected for each mask
    input  wire logic [N_MASKS*EXT_ID_WIDTH-1:0]  filter_ext_id_in,
    input  wire logic [N_MASKS*REG_WIDTH-1:0]     filter_byte1_in,
    // Operating field of the receive buffer tied to each mask
    input  wire logic [N_MASKS*OP_FIELD_WIDTH-1:0] rx_buffer_operating_field_in,
    // Received frame from the protocol engine
    input  wire logic                            frame_valid_in,
    input  wire logic                            extended_id_flag_in,
    input  wire logic [EXT_ID_WIDTH-1:0]         extended_identifier_bits_in,
    input  wire logic [REG_WIDTH-1:0]            frame_byte1_in,
    // Result of the extended part of the acceptance test, one bit per mask
    output logic      [N_MASKS-1:0]              ext_match_out,
    output logic                                 ext_match_valid_out
);

    typedef struct packed {
        logic [N_MASKS-1:0][REG_WIDTH-1:0] mask_ext_id_high_byte;
        logic [N_MASKS-1:0][REG_WIDTH-1:0] mask_ext_id_low_byte;
        logic [REG_WIDTH-1:0]              rd_data;
        logic [N_MASKS-1:0]                match;
        logic                              match_valid;
    } state_t;

    state_t               st_ff;
    state_t               nxt_st;
    logic [N_MASKS-1:0]   unit_match;
    logic [N_MASKS-1:0]   hit_high;
    logic [N_MASKS-1:0]   hit_low;
    logic                 wr_take;
    logic [REG_WIDTH-1:0] rd_value;

    mask_match_if mif [N_MASKS] ();

    // One comparison unit per mask, fed from the stored mask bytes
    for (genvar g = 0; g < N_MASKS; g++)
    begin : g_mask
        // Each mask owns two neighbouring byte addresses, one stride apart from the next mask
        assign hit_high[g]          = (reg_addr_in == ADDR_MASK0_EXT_ID_HIGH + 8'(g) * MASK_ADDR_STRIDE); // [R6]
        assign hit_low[g]           = (reg_addr_in == ADDR_MASK0_EXT_ID_LOW + 8'(g) * MASK_ADDR_STRIDE);  // [R4]

        assign mif[g].mask_high     = st_ff.mask_ext_id_high_byte[g];            // [R6]
        assign mif[g].mask_low      = st_ff.mask_ext_id_low_byte[g];             // [R1] [R2]
        assign mif[g].mask_top      = mask_ext_top_in[g*EXT_TOP_WIDTH +: EXT_TOP_WIDTH];   // [R5]
        assign mif[g].filter_ext_id = filter_ext_id_in[g*EXT_ID_WIDTH +: EXT_ID_WIDTH];
        assign mif[g].filter_byte1  = filter_byte1_in[g*REG_WIDTH +: REG_WIDTH];
        assign mif[g].op_field      = rx_buffer_operating_field_in[g*OP_FIELD_WIDTH +: OP_FIELD_WIDTH];
        assign mif[g].ext_id_flag   = extended_id_flag_in;
        assign mif[g].frame_ext_id  = extended_identifier_bits_in;
        assign mif[g].frame_byte1   = frame_byte1_in;
        assign unit_match[g]        = mif[g].match;

        mask_match_unit u_unit (
            .m (mif[g])
        );
    end

    // Writes land only in Configuration mode so filtering never sees a torn mask
    assign wr_take = reg_wr_en_in && config_mode_in;

    // Read selection; outside Configuration mode and at unmapped addresses it gives zero
    always_comb
    begin
        rd_value = READ_ZERO;
        if (config_mode_in)                                                     // [R3]
        begin
            for (int i = 0; i < N_MASKS; i++)
            begin
                if (hit_high[i])
                begin
                    rd_value = st_ff.mask_ext_id_high_byte[i];                  // [R6]
                end
                else if (hit_low[i])
                begin
                    rd_value = st_ff.mask_ext_id_low_byte[i];                   // [R4]
                end
            end
        end
    end

    // Next state: match result per frame, mask writes, read data held until the next read
    always_comb
    begin
        nxt_st             = st_ff;
        nxt_st.match_valid = frame_valid_in;
        // The result stands until the next frame, so a slow consumer still sees it
        if (frame_valid_in)
        begin
            nxt_st.match = unit_match;                                          // [R1] [R2] [R5] [R6]
        end

        // A decoded write replaces the whole byte; there is no partial-bit update
        for (int i = 0; i < N_MASKS; i++)
        begin
            if (wr_take && hit_high[i])
            begin
                nxt_st.mask_ext_id_high_byte[i] = reg_wr_data_in;               // [R6]
            end
            if (wr_take && hit_low[i])
            begin
                nxt_st.mask_ext_id_low_byte[i] = reg_wr_data_in;                // [R4]
            end
        end

        // Read data comes from the old contents, so a read beside a write sees the old byte
        if (reg_rd_en_in)
        begin
            nxt_st.rd_data = rd_value;
        end
    end

    // State register; masks reset to zero
    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            st_ff.mask_ext_id_high_byte <= {N_MASKS{MASK_RESET}};               // [R6]
            st_ff.mask_ext_id_low_byte  <= {N_MASKS{MASK_RESET}};               // [R4]
            st_ff.rd_data               <= READ_ZERO;
            st_ff.match                 <= '0;
            st_ff.match_valid           <= 1'b0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rd_data_out     = st_ff.rd_data;
    assign ext_match_out       = st_ff.match;
    assign ext_match_valid_out = st_ff.match_valid;

endmodule

// ---- can_bus_node.sv ----
// Behavioural CAN node that hands received frames to the mask block
`timescale 1ns/1ns
module can_bus_node
(
    input  wire logic        core_clk_in,
    output logic             frame_valid_out = 1'b0,
    output logic             ext_flag_out    = 1'b0,
    output logic      [17:0] ext_id_out      = 18'h0,
    output logic      [7:0]  byte1_out       = 8'h00
);
    // One frame per call; fields turn to their inverse after it so stale values cannot match by luck
    task automatic send(input logic x, input logic [17:0] id, input logic [7:0] b);
        @(negedge core_clk_in);
        {frame_valid_out, ext_flag_out, ext_id_out, byte1_out} = {1'b1, x, id, b};
        @(negedge core_clk_in);
        {frame_valid_out, ext_flag_out, ext_id_out, byte1_out} = {1'b0, ~x, ~id, ~b};
    endtask
endmodule

// ---- can_mask_chk.sv ----
// Concurrent checks on the ports of the extended-identifier mask block
`timescale 1ns/1ns
module can_mask_chk
    import can_mask_pkg::*;
#(
    parameter int N_MASKS = NUM_MASKS
)
(
    input wire logic                                core_clk_in,
    input wire logic                                arst_n_in,
    input wire logic [7:0]                          reg_addr_in,
    input wire logic                                reg_rd_en_in,
    input wire logic [REG_WIDTH-1:0]                reg_rd_data_out,
    input wire logic                                config_mode_in,
    input wire logic [N_MASKS*EXT_TOP_WIDTH-1:0]    mask_ext_top_in,
    input wire logic [N_MASKS*EXT_ID_WIDTH-1:0]     filter_ext_id_in,
    input wire logic [N_MASKS*OP_FIELD_WIDTH-1:0]   rx_buffer_operating_field_in,
    input wire logic                                frame_valid_in,
    input wire logic                                extended_id_flag_in,
    input wire logic [EXT_ID_WIDTH-1:0]             extended_identifier_bits_in,
    input wire logic [N_MASKS-1:0]                  ext_match_out,
    input wire logic                                ext_match_valid_out
);
    // All checks share the core clock and its reset
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!arst_n_in);
    AST_VALID_ECHO: assert property (frame_valid_in |=> ext_match_valid_out)
        else $error("match valid missing after frame");
    AST_READ_LOCKOUT: assert property (reg_rd_en_in && !config_mode_in |=> reg_rd_data_out == READ_ZERO)
        else $error("read outside configuration mode not zero");
    AST_UNMAPPED_ZERO: assert property (reg_rd_en_in && !(reg_addr_in inside {8'h22, 8'h23, 8'h26, 8'h27})
        |=> reg_rd_data_out == 8'h00) else $error("unmapped read not zero");
    AST_READ_HOLD: assert property (!reg_rd_en_in |=> $stable(reg_rd_data_out))
        else $error("read data moved without a read");
    AST_MATCH_HOLD: assert property (!frame_valid_in |=> $stable(ext_match_out) && !ext_match_valid_out)
        else $error("match result moved without a frame");
    AST_STD_PASS: assert property (frame_valid_in && !extended_id_flag_in
        && rx_buffer_operating_field_in[1:0] != 2'h0 |=> ext_match_out[0]) else $error("standard frame not passed");
    AST_TOP_MISS: assert property (frame_valid_in && extended_id_flag_in && ((extended_identifier_bits_in[17:16]
        ^ filter_ext_id_in[17:16]) & mask_ext_top_in[1:0]) != 2'h0 |=> !ext_match_out[0]) else $error("top bits ignored");
endmodule
bind can_ext_id_acceptance_mask can_mask_chk #(.N_MASKS(N_MASKS)) chk_u (.*);

// ---- tb_top.sv ----
// Self-checking bench for the extended-identifier mask block
`timescale 1ns/1ns
module tb_top;
    import can_mask_pkg::*;
    localparam byte_t      MV [4] = '{8'hff, 8'h0f, 8'h00, 8'hf0};
    localparam logic [7:0] AD [4] = '{8'h22, 8'h23, 8'h26, 8'h27};
    localparam int         FLIP [5] = '{0, 4, 12, 16, 17};
    logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, cfg = 1'b1, fv, fx, vout;
    logic [7:0]  addr = 8'h00, wd = 8'h00, rdat, fb;
    logic [3:0]  top = 4'h0, opf = 4'h0;
    logic [35:0] filt = {18'h1c3a5, 18'h2b4c6};
    logic [15:0] fb1 = {8'h3c, 8'h96};
    logic [17:0] fid;
    logic [1:0]  mout;
    int          bad_count = 0, check_count = 0, cyc = 0;
    initial forever #5 clk = ~clk;
    can_ext_id_acceptance_mask dut_u (.core_clk_in(clk), .arst_n_in(rst_n), .reg_addr_in(addr), .reg_wr_en_in(wr),
        .reg_wr_data_in(wd), .reg_rd_en_in(rd), .reg_rd_data_out(rdat), .config_mode_in(cfg), .mask_ext_top_in(top),
        .filter_ext_id_in(filt), .filter_byte1_in(fb1), .rx_buffer_operating_field_in(opf), .frame_valid_in(fv),
        .extended_id_flag_in(fx), .extended_identifier_bits_in(fid), .frame_byte1_in(fb), .ext_match_out(mout),
        .ext_match_valid_out(vout));
    can_bus_node node_u (.core_clk_in(clk), .frame_valid_out(fv), .ext_flag_out(fx), .ext_id_out(fid), .byte1_out(fb));
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        check_count++;
        if (seen !== want)
        begin
            bad_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic complete_run;
        if (bad_count == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Strobes last one cycle; read data is settled by the falling edge after the taking edge
    task automatic reg_op(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        {addr, wd, wr, rd} = {a, d, w, !w};
        @(negedge clk);
        {wr, rd} = 2'b00;
    endtask
    // Expected match worked out from the mask values this bench wrote
    function automatic logic exp_m(int g, logic x, logic [17:0] id, logic [7:0] b);
        if (x)
            return ((id ^ filt[g*18 +: 18]) & {top[g*2 +: 2], MV[2*g], MV[2*g+1]}) == 18'h0;
        return opf[g*2 +: 2] != 2'h0 || ((b ^ fb1[g*8 +: 8]) & MV[2*g+1]) == 8'h00;
    endfunction
    task automatic frame(input logic x, input logic [17:0] id, input logic [7:0] b);
        node_u.send(x, id, b);
        check({7'h0, vout}, 8'h01);
        check({6'h0, mout}, {6'h0, exp_m(1, x, id, b), exp_m(0, x, id, b)});
    endtask
    task automatic t_rw;
        for (int i = 0; i < 4; i++)
        begin
            reg_op(1'b0, AD[i], 8'h00);
            check(rdat, MASK_RESET);
        end
        for (int i = 0; i < 4; i++)
            reg_op(1'b1, AD[i], MV[i]);
        for (int i = 0; i < 4; i++)
        begin
            reg_op(1'b0, AD[i], 8'h00);
            check(rdat, MV[i]);
        end
        reg_op(1'b0, 8'h24, 8'h00);
        check(rdat, 8'h00);
    endtask
    // Outside configuration mode reads give zero, yet the stored masks keep filtering
    task automatic t_mode;
        cfg = 1'b0;
        reg_op(1'b0, 8'h22, 8'h00);
        check(rdat, READ_ZERO);
        reg_op(1'b1, 8'h23, 8'h55);
        cfg = 1'b1;
        reg_op(1'b0, 8'h23, 8'h00);
        check(rdat, MV[1]);
        cfg = 1'b0;
    endtask
    task automatic t_ext;
        top = 4'h6;
        frame(1'b1, filt[17:0], 8'h00);
        foreach (FLIP[k])
            frame(1'b1, filt[17:0] ^ (18'h1 << FLIP[k]), 8'h00);
        frame(1'b1, filt[35:18] ^ 18'h10010, 8'h00);
    endtask
    task automatic t_std;
        for (int op = 0; op < 4; op++)
        begin
            opf = {2'(3 - op), 2'(op)};
            frame(1'b0, 18'h0, fb1[7:0] ^ 8'h01);
            frame(1'b0, 18'h0, fb1[15:8] ^ 8'h10);
        end
        frame(1'b1, filt[35:18], 8'h00);
    endtask
    // A hang is cut short well past the roughly 72 cycles the run needs
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 2000)
        begin
            bad_count++;
            complete_run();
        end
    end
    initial
    begin
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        t_rw();
        t_mode();
        t_ext();
        t_std();
        complete_run();
    end
endmodule
